// ===== src/wdg_pkg.sv
// shared constants for the reloadable watchdog downcounter
package wdg_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int COUNT_W = 7;
  // register location and layout
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hd8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'hfe;
  localparam int ARM_POS = 0;
  localparam int SR_POS = 1;
  localparam int PERIOD_LSB = 2;
  localparam int PERIOD_MSB = 7;
  // counter layout
  localparam int TRIG_POS = 6;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h7f;
  localparam logic [COUNT_W-1:0] TRIG_EDGE = 7'h40;
  localparam logic [COUNT_W-1:0] TRIG_AFTER = 7'h3f;
  // timing
  localparam int PERIODS = 64;
  localparam int STEP_CYCLES = 3072;
  localparam int MIN_INSTR = 28;
  localparam int RST_HOLD_CYCLES = 4096;
  localparam int SYNC_SETTLE = 2;
endpackage

// ===== src/wdg_count_if.sv
// link between the control logic and the downcounter
`timescale 1ns/10ps
interface wdg_count_if;
  import wdg_pkg::*;
  logic load;
  logic [COUNT_W-1:0] load_value;
  logic run;
  logic hold;
  logic [COUNT_W-1:0] count;
  logic trig_fall;
  modport ctrl (output load, output load_value, output run, output hold,
                input count, input trig_fall);
  modport counter (input load, input load_value, input run, input hold,
                   output count, output trig_fall);
endinterface

// ===== src/wdg_downcounter.sv
// prescaled 7-bit downcounter with trigger-bit fall detection
`timescale 1ns/10ps
module wdg_downcounter #(
  parameter int STEP = wdg_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control side
  wdg_count_if.counter ctr
);
  import wdg_pkg::*;

  localparam int PW = $clog2(STEP);
  localparam logic [PW-1:0] STEP_LAST = PW'(STEP - 1);

  logic [PW-1:0] presc_ff;
  logic [COUNT_W-1:0] count_ff;
  logic fall_ff;
  logic tick;

  //////////////////////////////////////////////////////////////////////////////
  // one decrement every step: 64 steps from full count to the trigger fall
  assign tick = ctr.run && !ctr.load && !ctr.hold && (presc_ff == STEP_LAST);

  // prescaler restarts on load so a fresh period is never cut short
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      presc_ff <= '0;
    else if (ctr.load || ctr.hold || tick)
      presc_ff <= '0;
    else if (ctr.run)
      presc_ff <= presc_ff + 1'b1;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      count_ff <= COUNT_RESET;
    else if (ctr.hold)
      count_ff <= COUNT_RESET;
    else if (ctr.load)
      count_ff <= ctr.load_value;
    else if (tick)
      count_ff <= count_ff - 1'b1;
  end

  // trigger is bit 6 falling; the low six bits only set the period
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      fall_ff <= 1'b0;
    else
      fall_ff <= tick && (count_ff == TRIG_EDGE);
  end

  assign ctr.count = count_ff;
  assign ctr.trig_fall = fall_ff;

  trig_fall_value_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    ctr.trig_fall |-> (ctr.count == TRIG_AFTER) && !ctr.count[TRIG_POS])
    else $error("trigger fall without bit 6 dropping");

  frozen_count_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!ctr.run && !ctr.load && !ctr.hold) |=> $stable(ctr.count))
    else $error("counter moved while frozen");
endmodule

// ===== src/wdg_watchdog.sv
// watchdog control register, stop-mode handling and reset generation
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module wdg_watchdog #(
  parameter int STEP = wdg_pkg::STEP_CYCLES,
  parameter int RST_HOLD = wdg_pkg::RST_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [wdg_pkg::ADDR_W-1:0] addr,
  input wire logic [wdg_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [wdg_pkg::DATA_W-1:0] rdata,
  // processor core
  input wire logic stop_instr,
  input wire logic wake_irq,
  output logic stop_mode,
  output logic wait_mode,
  // pins and options
  input wire logic halt_permit_pin,
  input wire logic hw_activation,
  input wire logic ext_stop_ctrl,
  // reset outputs
  output logic wdg_reset,
  output logic reset_pin_out,
  output logic reset_pin_oe_n
);
  import wdg_pkg::*;

  localparam int HW = $clog2(RST_HOLD + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(RST_HOLD - 1);

  wdg_count_if ctr ();

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [1:0] settle_ff;
  logic hw_opt_ff;
  logic ext_opt_ff;
  logic arm_ff;
  logic holding_ff;
  logic [HW-1:0] hold_cnt_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic stop_mode_ff;
  logic wait_mode_ff;
  logic reset_pin_out_ff;
  logic reset_pin_oe_n_ff;
  logic armed;
  logic ctrl_wr;
  logic sr_zero_wr;
  logic fire;
  logic true_stop;
  logic nmi_level;
  logic [COUNT_W-1:0] nxt_load_value;
  logic [DATA_W-1:0] nxt_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: nmi level and the two option straps
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {ext_stop_ctrl, hw_activation, halt_permit_pin};
      sync2_ff <= sync1_ff;
    end
  end

  assign nmi_level = sync2_ff[0];

  // straps sampled on the first three edges, kept from the third once the synchroniser has settled
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle_ff <= 2'h0;
      hw_opt_ff <= 1'b0;
      ext_opt_ff <= 1'b0;
    end
    // third edge after release is the first that sees the strap through both flops
    else if (settle_ff != 2'(SYNC_SETTLE + 1))
    begin
      settle_ff <= settle_ff + 1'b1;
      hw_opt_ff <= sync2_ff[1];
      ext_opt_ff <= sync2_ff[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  assign ctrl_wr = wr_stb && (addr == CTRL_ADDR) && !holding_ff;
  assign sr_zero_wr = ctrl_wr && !wdata[SR_POS];
  assign armed = hw_opt_ff || arm_ff;

  // register bits 7..1 are the counter bits 0..6
  always_comb
  begin
    nxt_load_value = '0;
    for (int i = 0; i < COUNT_W; i++)
      nxt_load_value[i] = wdata[DATA_W - 1 - i];
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      arm_ff <= CTRL_RESET[ARM_POS];
    else if (holding_ff)
      arm_ff <= CTRL_RESET[ARM_POS];
    else if (ctrl_wr && wdata[ARM_POS])
      arm_ff <= 1'b1;
  end

  // reading shows the live count, reversed, and the arm state
  always_comb
  begin
    nxt_rdata = '0;
    for (int i = 0; i < COUNT_W; i++)
      nxt_rdata[DATA_W - 1 - i] = ctr.count[i];
    nxt_rdata[ARM_POS] = armed;
  end

  // unmapped reads and idle cycles return zero
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_ff <= '0;
    else if (rd_stb && (addr == CTRL_ADDR))
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter control; software keeps the count alive by rewriting it
  assign ctr.load = ctrl_wr && wdata[SR_POS];
  assign ctr.load_value = nxt_load_value;
  assign ctr.hold = holding_ff;
  assign ctr.run = !stop_mode_ff;

  wdg_downcounter #(
    .STEP(STEP)
  ) u_counter (
    .clock(clock),
    .sys_rst(sys_rst),
    .ctr(ctr.counter)
  );

  // disarmed expiry just wraps the free timer
  assign fire = !holding_ff && ((armed && ctr.trig_fall) || sr_zero_wr);

  //////////////////////////////////////////////////////////////////////////////
  // reset stretch stands in for the oscillator stabilisation delay
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      holding_ff <= 1'b0;
      hold_cnt_ff <= '0;
    end
    else if (fire)
    begin
      holding_ff <= 1'b1;
      hold_cnt_ff <= '0;
    end
    else if (holding_ff)
    begin
      holding_ff <= (hold_cnt_ff != HOLD_LAST);
      hold_cnt_ff <= hold_cnt_ff + 1'b1;
    end
  end

  // pin pulled low only while our reset stands; released otherwise
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reset_pin_out_ff <= 1'b0;
      reset_pin_oe_n_ff <= 1'b1;
    end
    else
    begin
      reset_pin_out_ff <= 1'b0;
      reset_pin_oe_n_ff <= !(fire || (holding_ff && (hold_cnt_ff != HOLD_LAST)));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stop handling: true stop freezes the counter, wait keeps it counting
  assign true_stop = !armed || (ext_opt_ff && nmi_level);

  // a stop in the same cycle as a wake wins, so the request is not lost
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stop_mode_ff <= 1'b0;
      wait_mode_ff <= 1'b0;
    end
    else if (fire || holding_ff)
    begin
      stop_mode_ff <= 1'b0;
      wait_mode_ff <= 1'b0;
    end
    else if (stop_instr)
    begin
      stop_mode_ff <= true_stop;
      wait_mode_ff <= !true_stop;
    end
    else if (wake_irq)
    begin
      stop_mode_ff <= 1'b0;
      wait_mode_ff <= 1'b0;
    end
  end

  assign rdata = rdata_ff;
  assign stop_mode = stop_mode_ff;
  assign wait_mode = wait_mode_ff;
  assign wdg_reset = holding_ff;
  assign reset_pin_out = reset_pin_out_ff;
  assign reset_pin_oe_n = reset_pin_oe_n_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sr_zero_fire_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    sr_zero_wr |=> wdg_reset && !reset_pin_oe_n)
    else $error("reboot bit write did not reset");

  expiry_fire_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (armed && ctr.trig_fall && !holding_ff) |=> wdg_reset)
    else $error("armed expiry did not reset");

  disarmed_quiet_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!armed && !sr_zero_wr && !holding_ff) |=> !wdg_reset)
    else $error("reset while disarmed");

  arm_sticky_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (arm_ff && !holding_ff && !fire) |=> arm_ff)
    else $error("watchdog disarmed without reset");

  reset_hold_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(wdg_reset) |-> wdg_reset[*8] ##0 (ctr.count == COUNT_RESET))
    else $error("watchdog reset too short");

  pin_low_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(wdg_reset) |-> !reset_pin_oe_n && !reset_pin_out)
    else $error("reset pin not driven low");

  hw_wait_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (stop_instr && hw_opt_ff && !ext_opt_ff && !fire && !holding_ff)
      |=> wait_mode && !stop_mode)
    else $error("stop not turned into wait");

  ext_stop_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (stop_instr && armed && ext_opt_ff && nmi_level && !fire && !holding_ff)
      |=> stop_mode ##1 (!stop_mode || $stable(ctr.count)))
    else $error("external stop did not freeze");

  reload_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    ctr.load |=> ctr.count == $past(nxt_load_value))
    else $error("write did not reload counter");

  arm_read_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (rd_stb && (addr == CTRL_ADDR) && hw_opt_ff) |=> rdata[ARM_POS])
    else $error("arm bit not read as one");
endmodule

// ===== sim/core_model.sv
// processor core stand-in: control register accesses and stop/wake events
`timescale 1ns/10ps
module core_model (
  // clock
  input wire logic clock,
  // register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rdata,
  // core events
  output logic stop_instr,
  output logic wake_irq
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    stop_instr = 1'b0;
    wake_irq = 1'b0;
  end
  ////////////////////////////////////////
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
  task automatic ev(input logic wake);
    @(posedge clock);
    stop_instr <= !wake;
    wake_irq <= wake;
    @(posedge clock);
    stop_instr <= 1'b0;
    wake_irq <= 1'b0;
    #1;
  endtask
endmodule

// ===== sim/tb_digital_watchdog_timer.sv
// self-checking bench for the watchdog control block
`timescale 1ns/10ps
`define CHK(nm, e, s) \
  begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", nm, e, s); end end
module tb_digital_watchdog_timer;
  import wdg_pkg::*;
  localparam int STEP_SIM = 8;
  localparam int HOLD_SIM = 16;
  logic clock = 1'b0;
  logic sys_rst;
  logic halt_permit_pin;
  logic hw_activation;
  logic ext_stop_ctrl;
  logic [7:0] addr, wdata, rdata, r1, r2;
  logic wr_stb, rd_stb, stop_instr, wake_irq, stop_mode, wait_mode;
  logic wdg_reset, reset_pin_out, reset_pin_oe_n;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] seed = 32'h7663;
  wdg_watchdog #(.STEP(STEP_SIM), .RST_HOLD(HOLD_SIM)) wdg_watchdog_i (
    .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .stop_instr(stop_instr),
    .wake_irq(wake_irq), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .halt_permit_pin(halt_permit_pin), .hw_activation(hw_activation),
    .ext_stop_ctrl(ext_stop_ctrl), .wdg_reset(wdg_reset),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));
  core_model core_model_i (
    .clock(clock), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .stop_instr(stop_instr),
    .wake_irq(wake_irq));
  always #10 clock = ~clock;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // period bits are reversed: register bit 7 is the counter lsb
  function automatic int tmo(input logic [7:0] v);
    return ({v[2], v[3], v[4], v[5], v[6], v[7]} + 1) * STEP_SIM;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic do_reset(input logic hw, input logic ext);
    @(posedge clock);
    sys_rst <= 1'b1;
    hw_activation <= hw;
    ext_stop_ctrl <= ext;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] e);
    core_model_i.rd(CTRL_ADDR, r1);
    `CHK(nm, e, r1)
  endtask
  task automatic count_until(input logic lvl);
    // step off the edge so a value launched there has settled
    #1;
    n = 0;
    while (wdg_reset !== lvl && n < 2000)
    begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  task automatic expire(input logic [7:0] v);
    core_model_i.wr(CTRL_ADDR, v);
    count_until(1'b1);
    `CHK("expiry", 1'b1, n >= tmo(v) && n <= tmo(v) + 3)
    `CHK("pin oe", 1'b0, reset_pin_oe_n)
    count_until(1'b0);
    `CHK("hold", 1'b1, n >= HOLD_SIM - 1 && n <= HOLD_SIM + 1)
    rd_chk("reinit", CTRL_RESET);
  endtask
  ////////////////////////////////////////
  initial
  begin
    sys_rst <= 1'b1;
    halt_permit_pin <= 1'b0;
    hw_activation <= 1'b0;
    ext_stop_ctrl <= 1'b0;
    do_reset(1'b0, 1'b0);
    rd_chk("reset value", CTRL_RESET);
    core_model_i.rd(8'h5a, r1);
    `CHK("unmapped", 8'h00, r1)
    core_model_i.wr(CTRL_ADDR, 8'h82);
    repeat (10) @(posedge clock);
    rd_chk("bit order", 8'h02);
    count_until(1'b1);
    `CHK("free run", 1'b0, wdg_reset)
    core_model_i.ev(1'b0);
    `CHK("stop", 1'b1, stop_mode)
    core_model_i.rd(CTRL_ADDR, r2);
    repeat (30) @(posedge clock);
    rd_chk("frozen", r2);
    core_model_i.ev(1'b1);
    repeat (30) @(posedge clock);
    core_model_i.rd(CTRL_ADDR, r1);
    `CHK("resumed", 1'b1, r1 !== r2)
    $display("test disarmed done");
    core_model_i.wr(CTRL_ADDR, 8'hc3);
    core_model_i.wr(CTRL_ADDR, 8'hc2);
    rd_chk("no disarm", 8'hc3);
    repeat (30)
    begin
      repeat (16) @(posedge clock);
      core_model_i.wr(CTRL_ADDR, 8'hc3);
    end
    rd_chk("reloaded", 8'hc3);
    expire(8'h03);
    expire(8'hff);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      // pin level is a don't-care without the external stop option
      @(posedge clock);
      halt_permit_pin <= seed[8];
      expire({seed[5:0], 2'b11});
    end
    core_model_i.wr(CTRL_ADDR, 8'hfc);
    count_until(1'b1);
    `CHK("self reboot", 1'b1, n == 0)
    count_until(1'b0);
    $display("test armed done");
    do_reset(1'b1, 1'b0);
    rd_chk("hw armed", 8'hff);
    core_model_i.wr(CTRL_ADDR, 8'hfe);
    rd_chk("hw fixed", 8'hff);
    core_model_i.ev(1'b0);
    `CHK("hw wait", 2'b01, {stop_mode, wait_mode})
    @(posedge clock);
    halt_permit_pin <= 1'b1;
    do_reset(1'b1, 1'b1);
    core_model_i.ev(1'b0);
    repeat (600) @(posedge clock);
    `CHK("ext stop", 2'b10, {stop_mode, wait_mode})
    core_model_i.ev(1'b1);
    @(posedge clock);
    halt_permit_pin <= 1'b0;
    repeat (4) @(posedge clock);
    core_model_i.ev(1'b0);
    `CHK("ext wait", 2'b01, {stop_mode, wait_mode})
    count_until(1'b1);
    `CHK("wait counts", 1'b1, wdg_reset)
    $display("test options done");
    summarize();
  end
endmodule
